/* blink_coder.sv */
// flash sequencer that shows a decimal error code on one led
`timescale 1ns/10ps
`default_nettype none

module blink_coder #(
  parameter relay_status_pkg::ms_t SHORT_ON = relay_status_pkg::SHORT_ON_MS,
  parameter relay_status_pkg::ms_t SHORT_OFF = relay_status_pkg::SHORT_OFF_MS,
  parameter relay_status_pkg::ms_t PREFIX_PAUSE = relay_status_pkg::PREFIX_PAUSE_MS,
  parameter relay_status_pkg::ms_t DIGIT_PAUSE = relay_status_pkg::DIGIT_PAUSE_MS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic tick,
  input wire logic run,
  input wire relay_status_pkg::err_code_t code,
  output logic led
);
  import relay_status_pkg::*;

  blink_state_t s_r;
  blink_state_t s_nxt;
  ms_t lim;
  ms_t ms_inc;
  logic done;
  logic [3:0] cur_digit;
  logic [4:0] want;
  logic [4:0] flash_inc;

  // ---------------------------------------------------------------
  // phase length and digit flash count
  // ---------------------------------------------------------------
  always_comb begin
    case (s_r.phase)
      BL_SHORT_ON: lim = SHORT_ON;
      BL_SHORT_OFF: lim = SHORT_OFF;
      BL_PREFIX: lim = PREFIX_PAUSE;
      BL_LONG_ON: lim = LONG_ON_MS;
      BL_LONG_OFF: lim = LONG_OFF_MS;
      default: lim = DIGIT_PAUSE;
    endcase
    ms_inc = s_r.ms + 12'h001;
    done = tick && (ms_inc >= lim);
    cur_digit = code.digit[s_r.idx];
    want = (cur_digit == 4'h0) ? ZERO_FLASHES : {1'b0, cur_digit};
    flash_inc = s_r.flashes + 5'h01;
  end

  // ---------------------------------------------------------------
  // sequence: prefix, pause, digits with gaps, then repeat
  // ---------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    if (!run) begin
      s_nxt = '0;
    end else if (s_r.phase == BL_IDLE) begin
      // start on a tick so the first short flash is as long as the others
      if (tick) begin
        s_nxt.phase = BL_SHORT_ON;
        s_nxt.led = 1'b1;
      end
    end else if (tick) begin
      s_nxt.ms = done ? '0 : ms_inc;
      if (done) begin
        case (s_r.phase)
          BL_SHORT_ON: begin
            s_nxt.phase = BL_SHORT_OFF;
            s_nxt.led = 1'b0;
            s_nxt.flashes = flash_inc;
          end
          BL_SHORT_OFF: begin
            if (s_r.flashes == PREFIX_FLASHES) begin
              s_nxt.phase = BL_PREFIX;
              s_nxt.flashes = '0;
            end else begin
              s_nxt.phase = BL_SHORT_ON;
              s_nxt.led = 1'b1;
            end
          end
          BL_PREFIX: begin
            s_nxt.phase = BL_LONG_ON;
            s_nxt.led = 1'b1;
          end
          BL_LONG_ON: begin
            s_nxt.led = 1'b0;
            // digit done: dark gap starts right after the last flash
            if (flash_inc == want) begin
              s_nxt.phase = BL_GAP;
              s_nxt.flashes = '0;
            end else begin
              s_nxt.phase = BL_LONG_OFF;
              s_nxt.flashes = flash_inc;
            end
          end
          BL_LONG_OFF: begin
            s_nxt.phase = BL_LONG_ON;
            s_nxt.led = 1'b1;
          end
          default: begin
            s_nxt.led = 1'b1;
            if (s_r.idx == code.last) begin
              s_nxt.phase = BL_SHORT_ON;
              s_nxt.idx = '0;
            end else begin
              s_nxt.phase = BL_LONG_ON;
              s_nxt.idx = s_r.idx + 2'h1;
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign led = s_r.led;

endmodule
`default_nettype wire

/* ms_tick_gen.sv */
// millisecond enable pulse divided down from the system clock
`timescale 1ns/10ps
`default_nettype none

module ms_tick_gen #(
  parameter relay_status_pkg::tick_cnt_t DIV = relay_status_pkg::MS_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  output logic tick
);
  import relay_status_pkg::*;

  div_state_t s_r;
  div_state_t s_nxt;

  // wrap the count and pulse for one cycle at the end of each period
  always_comb begin
    s_nxt = s_r;
    s_nxt.tick = 1'b0;
    if (s_r.cnt >= DIV - 24'h000001) begin
      s_nxt.cnt = '0;
      s_nxt.tick = 1'b1;
    end else begin
      s_nxt.cnt = s_r.cnt + 24'h000001;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tick = s_r.tick;

endmodule
`default_nettype wire

/* relay_link_partner.sv */
// far side: upstream link outputs and readback of the safety output pins
`timescale 1ns/10ps
`default_nettype none
module relay_link_partner (
  input wire logic clk,
  input wire logic rst,
  input wire logic and_cmd,
  input wire logic or_cmd,
  input wire logic stuck_2,
  input wire relay_status_pkg::safe_out_t safe_out,
  output logic and_link,
  output logic or_link,
  output logic sense_1,
  output logic sense_2
);
  import relay_status_pkg::*;
  // upstream units switch just after an edge; pin readback trails the drive by a cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      and_link <= 1'b0;
      or_link <= 1'b0;
      sense_1 <= 1'b0;
      sense_2 <= 1'b0;
    end else begin
      and_link <= and_cmd;
      or_link <= or_cmd;
      sense_1 <= safe_out.out_1;
      sense_2 <= safe_out.out_2 | stuck_2; // stuck_2 shorts pin two to the supply
    end
  end
endmodule
`default_nettype wire

/* relay_status.sv */
// status indication, fault latch, link gating and output test of the relay
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - code starts with three short flashes, pause
// - each digit is that many one-second flashes
// - up to four digits, dark gap between
// - whole sequence repeats while fault is latched
// - digit zero is sixteen flashes
// - supply drop over 20 ms is a fault
// - fault stays until supply off one second
// - power led flashes in init, steady when ready and started
// - channel leds follow safety outputs
// - channel leds alternate on open loop/channel, only while outputs are off
// - power led flashes for bad mode, no start; a bad mode once ready latches fault code 3 with the power led steady
// - and link gates outputs, or link adds
// - brief test pulses verify active outputs
// - fault display cleared only by power cycle
module relay_status #(
  parameter relay_status_pkg::tick_cnt_t MS_DIV = relay_status_pkg::MS_CYCLES,
  parameter relay_status_pkg::ms_t SHORT_ON = relay_status_pkg::SHORT_ON_MS,
  parameter relay_status_pkg::ms_t SHORT_OFF = relay_status_pkg::SHORT_OFF_MS,
  parameter relay_status_pkg::ms_t PREFIX_PAUSE = relay_status_pkg::PREFIX_PAUSE_MS,
  parameter relay_status_pkg::ms_t DIGIT_PAUSE = relay_status_pkg::DIGIT_PAUSE_MS
) (
  input wire logic clk,
  input wire logic rst,
  input wire relay_status_pkg::relay_in_t status_in,
  input wire relay_status_pkg::err_code_t ext_code,
  output relay_status_pkg::led_out_t leds,
  output relay_status_pkg::safe_out_t safe_out,
  output logic fault_latched
);
  import relay_status_pkg::*;

  typedef struct packed {
    relay_phase_t phase;
    ms_t off_ms;
    logic cycled;
    err_code_t code;
    logic code_chan;
    ms_t blink_ms;
    logic blink;
    ms_t test_ms;
    logic [7:0] test_cyc;
    logic test_on;
    logic test_sel;
    logic out_1;
    logic out_2;
    logic power_led;
    logic led_1;
    logic led_2;
    logic fault;
  } relay_state_t;

  relay_state_t s_r;
  relay_state_t s_nxt;

  logic tick;
  logic code_led;
  logic en;
  logic en_cmd;
  logic test_fail;
  logic fault_hit;
  err_code_t hit_code;
  logic hit_chan;
  logic alt_mode;

  // ---------------------------------------------------------------
  // time base and flash code sequencer
  // ---------------------------------------------------------------
  ms_tick_gen #(
    .DIV(MS_DIV)
  ) u_tick (
    .clk(clk),
    .rst(rst),
    .tick(tick)
  );

  // short flash and pause timings are parameters so a product can retune them
  blink_coder #(
    .SHORT_ON(SHORT_ON),
    .SHORT_OFF(SHORT_OFF),
    .PREFIX_PAUSE(PREFIX_PAUSE),
    .DIGIT_PAUSE(DIGIT_PAUSE)
  ) u_coder (
    .clk(clk),
    .rst(rst),
    .tick(tick),
    .run(s_r.phase == RP_FAULT),
    .code(s_r.code),
    .led(code_led)
  );

  // ---------------------------------------------------------------
  // output enable, test check and fault source selection
  // ---------------------------------------------------------------
  // own function or the or link, always qualified by the and link
  always_comb begin
    en = (s_r.phase == RP_READY) && status_in.supply_ok && status_in.start_done &&
         (status_in.own_safety_ok || status_in.or_link_input) &&
         status_in.and_link_input;
    // output still high at the end of its pulse means it is shorted high
    test_fail = en && s_r.test_on && (s_r.test_cyc == TEST_PULSE_CYC - 8'h01) &&
                (s_r.test_sel ? status_in.sense_2 : status_in.sense_1);
    alt_mode = status_in.feedback_open || status_in.one_channel_open;
  end

  // first fault wins; later faults are ignored until the power cycle
  always_comb begin
    fault_hit = 1'b0;
    hit_code = CODE_SUPPLY;
    hit_chan = 1'b0;
    if (s_r.phase != RP_FAULT) begin
      if (!status_in.supply_ok && (s_r.off_ms > SUPPLY_DROP_MS)) begin
        fault_hit = 1'b1;
      end else if (test_fail) begin
        fault_hit = 1'b1;
        hit_code = CODE_OUT_SHORT;
        hit_chan = s_r.test_sel;
      end else if ((s_r.phase == RP_READY) && !status_in.mode_valid) begin
        fault_hit = 1'b1;
        hit_code = CODE_MODE;
      end else if (status_in.ext_fault) begin
        fault_hit = 1'b1;
        hit_code = ext_code;
        hit_chan = status_in.ext_fault_chan;
      end
    end
    en_cmd = en && !fault_hit;
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;

    // shared slow blink for the power led and the alternate pattern
    if (tick) begin
      if (s_r.blink_ms + 12'h001 >= STATUS_BLINK_MS) begin
        s_nxt.blink_ms = '0;
        s_nxt.blink = !s_r.blink;
      end else begin
        s_nxt.blink_ms = s_r.blink_ms + 12'h001;
      end
    end

    // supply watch: count off time, saturating at the restart limit
    if (!status_in.supply_ok) begin
      if (tick && (s_r.off_ms < POWER_OFF_MS)) begin
        s_nxt.off_ms = s_r.off_ms + 12'h001;
      end
      if (s_r.off_ms >= POWER_OFF_MS) begin
        s_nxt.cycled = 1'b1;
      end
    end else begin
      s_nxt.off_ms = '0;
      s_nxt.cycled = 1'b0;
      // a short drop leaves the latch alone, a full cycle restarts
      if ((s_r.phase == RP_FAULT) && s_r.cycled) begin
        s_nxt.phase = RP_INIT;
        s_nxt.fault = 1'b0;
        s_nxt.code = '0;
        s_nxt.code_chan = 1'b0;
      end
    end

    // mode detection ends the init phase
    if ((s_r.phase == RP_INIT) && status_in.supply_ok && status_in.mode_valid) begin
      s_nxt.phase = RP_READY;
    end

    // latch a new fault over whatever the phase logic chose
    if (fault_hit) begin
      s_nxt.phase = RP_FAULT;
      s_nxt.fault = 1'b1;
      s_nxt.code = hit_code;
      s_nxt.code_chan = hit_chan;
    end

    // test pulse timer, alternating between the two outputs
    if (!en_cmd) begin
      s_nxt.test_on = 1'b0;
      s_nxt.test_ms = '0;
      s_nxt.test_cyc = '0;
    end else if (s_r.test_on) begin
      if (s_r.test_cyc == TEST_PULSE_CYC - 8'h01) begin
        s_nxt.test_on = 1'b0;
        s_nxt.test_cyc = '0;
        s_nxt.test_sel = !s_r.test_sel;
      end else begin
        s_nxt.test_cyc = s_r.test_cyc + 8'h01;
      end
    end else if (tick) begin
      if (s_r.test_ms + 12'h001 >= TEST_INTERVAL_MS) begin
        s_nxt.test_ms = '0;
        s_nxt.test_on = 1'b1;
      end else begin
        s_nxt.test_ms = s_r.test_ms + 12'h001;
      end
    end

    // outputs drop only for the selected channel while its pulse runs
    s_nxt.out_1 = en_cmd && !(s_nxt.test_on && !s_nxt.test_sel);
    s_nxt.out_2 = en_cmd && !(s_nxt.test_on && s_nxt.test_sel);

    // power led: dark without supply, flashing until ready and started
    if (!status_in.supply_ok) begin
      s_nxt.power_led = 1'b0;
    end else if (s_nxt.phase == RP_INIT) begin
      s_nxt.power_led = s_nxt.blink;
    end else if ((s_nxt.phase == RP_READY) && !status_in.start_done) begin
      s_nxt.power_led = s_nxt.blink;
    end else begin
      s_nxt.power_led = 1'b1;
    end

    // channel leds: code, alternate pattern, else the output state
    if (!status_in.supply_ok) begin
      s_nxt.led_1 = 1'b0;
      s_nxt.led_2 = 1'b0;
    end else if (s_r.phase == RP_FAULT) begin
      s_nxt.led_1 = !s_r.code_chan && code_led;
      s_nxt.led_2 = s_r.code_chan && code_led;
    end else if (alt_mode && !en_cmd) begin
      s_nxt.led_1 = s_nxt.blink;
      s_nxt.led_2 = !s_nxt.blink;
    end else begin
      // follows the command, so test pulses never flicker the led
      s_nxt.led_1 = en_cmd;
      s_nxt.led_2 = en_cmd;
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // every output is a field of the state register
  assign leds.power_led = s_r.power_led;
  assign leds.first_channel_led = s_r.led_1;
  assign leds.second_channel_led = s_r.led_2;
  assign safe_out.out_1 = s_r.out_1;
  assign safe_out.out_2 = s_r.out_2;
  assign fault_latched = s_r.fault;

endmodule
`default_nettype wire

/* relay_status_pkg.sv */
// constants, timing counts and carrier types for the relay status logic
package relay_status_pkg;

  // ---------------------------------------------------------------
  // clock and time base
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned MS_NS = 1000000;

  typedef logic [23:0] tick_cnt_t;
  typedef logic [11:0] ms_t;

  // cycles per millisecond tick, time divided by clock period
  localparam tick_cnt_t MS_CYCLES = tick_cnt_t'(MS_NS / CLK_PERIOD_NS);

  // ---------------------------------------------------------------
  // supervision times in milliseconds
  // ---------------------------------------------------------------
  localparam ms_t SUPPLY_DROP_MS = 12'h014;  // 20 ms, longer drop is a fault
  localparam ms_t POWER_OFF_MS = 12'h3e8;    // 1000 ms off needed to restart
  localparam ms_t STATUS_BLINK_MS = 12'h0fa; // 250 ms half period, power/alternate blink
  localparam ms_t TEST_INTERVAL_MS = 12'h064; // 100 ms between output tests

  // output test pulse, a least time so it rounds up
  localparam int unsigned TEST_PULSE_NS = 500;
  localparam logic [7:0] TEST_PULSE_CYC =
    8'((TEST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ---------------------------------------------------------------
  // flash code timing in milliseconds
  // ---------------------------------------------------------------
  localparam ms_t DIGIT_PERIOD_MS = 12'h3e8; // one long flash per second
  localparam ms_t LONG_ON_MS = 12'h1f4;
  localparam ms_t LONG_OFF_MS = DIGIT_PERIOD_MS - LONG_ON_MS;
  localparam ms_t SHORT_ON_MS = 12'h096;
  localparam ms_t SHORT_OFF_MS = 12'h096;
  localparam ms_t PREFIX_PAUSE_MS = 12'h7d0; // both pauses well above one second
  localparam ms_t DIGIT_PAUSE_MS = 12'h7d0;
  localparam logic [4:0] PREFIX_FLASHES = 5'h03;
  localparam logic [4:0] ZERO_FLASHES = 5'h10;

  // ---------------------------------------------------------------
  // carrier types
  // ---------------------------------------------------------------
  // digit[0] is shown first, last is the digit count minus one
  typedef struct packed {
    logic [1:0] last;
    logic [3:0][3:0] digit;
  } err_code_t;

  localparam err_code_t CODE_SUPPLY = '{last: 2'h1, digit: 16'h0028};   // 8, 2
  localparam err_code_t CODE_OUT_SHORT = '{last: 2'h0, digit: 16'h000a}; // 10
  localparam err_code_t CODE_MODE = '{last: 2'h0, digit: 16'h0003};     // 3

  typedef struct packed {
    logic supply_ok;
    logic own_safety_ok;
    logic and_link_input;
    logic or_link_input;
    logic mode_valid;
    logic start_done;
    logic feedback_open;
    logic one_channel_open;
    logic ext_fault;
    logic ext_fault_chan;
    logic sense_1;
    logic sense_2;
  } relay_in_t;

  typedef struct packed {
    logic power_led;
    logic first_channel_led;
    logic second_channel_led;
  } led_out_t;

  typedef struct packed {
    logic out_1;
    logic out_2;
  } safe_out_t;

  typedef struct packed {
    tick_cnt_t cnt;
    logic tick;
  } div_state_t;

  typedef enum logic [2:0] {
    BL_IDLE, BL_SHORT_ON, BL_SHORT_OFF, BL_PREFIX, BL_LONG_ON, BL_LONG_OFF, BL_GAP
  } blink_phase_t;

  typedef struct packed {
    blink_phase_t phase;
    ms_t ms;
    logic [4:0] flashes;
    logic [1:0] idx;
    logic led;
  } blink_state_t;

  typedef enum logic [1:0] {RP_INIT, RP_READY, RP_FAULT} relay_phase_t;

endpackage

/* relay_status_sva.sv */
// port assertions for the relay status block
`timescale 1ns/10ps
`default_nettype none
module relay_status_sva #(
  parameter relay_status_pkg::tick_cnt_t MS_DIV = relay_status_pkg::MS_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire relay_status_pkg::relay_in_t status_in,
  input wire relay_status_pkg::err_code_t ext_code,
  input wire relay_status_pkg::led_out_t leds,
  input wire relay_status_pkg::safe_out_t safe_out,
  input wire logic fault_latched
);
  import relay_status_pkg::*;
  // wide enough that the restart limit fits at the full-rate divider
  logic [31:0] low_r;
  logic [7:0] pls_r;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // ---------------------------------------------------------------
  // helper counts
  // ---------------------------------------------------------------
  // supply-away count saturates so a long power-off never wraps to zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      low_r <= '0;
      pls_r <= '0;
    end else begin
      low_r <= status_in.supply_ok ? 32'h00000000 : low_r + {31'h00000000, ~&low_r};
      pls_r <= (!safe_out.out_1 && safe_out.out_2) ? pls_r + 8'h01 : 8'h00;
    end
  end
  // ---------------------------------------------------------------
  // sequences and assertions
  // ---------------------------------------------------------------
  sequence s_link_cut;
    !status_in.and_link_input;
  endsequence
  sequence s_ext_req;
    status_in.ext_fault && status_in.supply_ok && !fault_latched;
  endsequence
  sequence s_coding;
    fault_latched && $past(fault_latched, 3);
  endsequence
  a_fault_outs_low: assert property (fault_latched |-> safe_out == 2'b00)
    else $error("outputs on while fault latched");
  a_link_gate: assert property (s_link_cut |=> safe_out == 2'b00)
    else $error("outputs on with and link low");
  a_led_one: assert property (safe_out.out_1 |-> leds.first_channel_led)
    else $error("first led dark with output one high");
  a_led_two: assert property (safe_out.out_2 |-> leds.second_channel_led)
    else $error("second led dark with output two high");
  a_drop_fault: assert property (low_r >= 22 * MS_DIV + 2 |-> fault_latched)
    else $error("long supply drop not latched");
  a_latch_holds: assert property (fault_latched && low_r < 999 * MS_DIV |=> fault_latched)
    else $error("fault cleared without long power-off");
  a_code_one_led: assert property (s_coding |-> !(leds.first_channel_led && leds.second_channel_led))
    else $error("code shown on both leds");
  a_pulse_brief: assert property (pls_r <= 8'h14)
    else $error("test pulse too long");
  a_pulse_quiet: assert property (!safe_out.out_1 && safe_out.out_2 |-> leds.first_channel_led)
    else $error("test pulse seen on led");
  a_ext_latch: assert property (s_ext_req |=> fault_latched)
    else $error("fault request not latched");
endmodule
`default_nettype wire

/* relay_status_test.sv */
// self-checking bench for the relay status block
`timescale 1ns/10ps
`default_nettype none
module relay_status_test;
  import relay_status_pkg::*;
  localparam int D = 2; // ms divider cut to 2 cycles so a full code round fits the run
  logic clk = 1'b0;
  logic rst = 1'b1;
  relay_in_t stim_r = '{supply_ok: 1'b1, default: 1'b0};
  relay_in_t status_in;
  err_code_t ext_code = '0;
  led_out_t leds;
  safe_out_t safe_out;
  logic fault_latched;
  logic and_cmd = 1'b1;
  logic or_cmd = 1'b0;
  logic stuck_2 = 1'b0;
  logic and_link, or_link, sense_1, sense_2;
  int fail_count = 0;
  int checks_done = 0;

  always #12.5 clk = ~clk;

  // link and readback bits come from the partner, the rest from the bench
  always_comb begin
    status_in = stim_r;
    status_in.and_link_input = and_link;
    status_in.or_link_input = or_link;
    status_in.sense_1 = sense_1;
    status_in.sense_2 = sense_2;
  end

  relay_link_partner u_far (.clk(clk), .rst(rst), .and_cmd(and_cmd), .or_cmd(or_cmd), .stuck_2(stuck_2),
    .safe_out(safe_out), .and_link(and_link), .or_link(or_link), .sense_1(sense_1), .sense_2(sense_2));
  relay_status #(.MS_DIV(tick_cnt_t'(D))) u_dut (.clk(clk), .rst(rst), .status_in(status_in),
    .ext_code(ext_code), .leds(leds), .safe_out(safe_out), .fault_latched(fault_latched));

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic test_done();
    if (fail_count == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic give_up();
    fail_count++;
    $display("BAD %0t wait ran out", $time);
    test_done();
  endtask
  // sample 1 ns after the edge so the edge's own updates have landed
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  function automatic logic cur(input int which);
    case (which)
      0: return fault_latched;
      1: return safe_out.out_1;
      2: return leds.first_channel_led;
      default: return leds.power_led;
    endcase
  endfunction
  task automatic wait_sig(input int which, input logic want, input int lim);
    int n;
    n = 0;
    while (cur(which) !== want) begin
      if (n == lim) give_up();
      n++;
      step(1);
    end
  endtask
  task automatic run_len(input int which, input logic lvl, input int lim, output int len);
    len = 0;
    while (cur(which) === lvl) begin
      if (len == lim) give_up();
      len++;
      step(1);
    end
  endtask
  task automatic toggles(input int which, input int n, output int t);
    logic last;
    t = 0;
    last = cur(which);
    repeat (n) begin
      step(1);
      t += (cur(which) !== last);
      last = cur(which);
    end
  endtask
  task automatic flash(output int on, output int off);
    wait_sig(2, 1'b1, 6000);
    chk(leds.second_channel_led, 1'b0);
    run_len(2, 1'b1, 6000, on);
    run_len(2, 1'b0, 6000, off);
  endtask
  task automatic power_cycle(input int off);
    @(posedge clk);
    stim_r.supply_ok <= 1'b0;
    repeat (off) @(posedge clk);
    stim_r.supply_ok <= 1'b1;
    step(3);
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_init();
    int t;
    toggles(3, 1300, t);
    chk(t >= 2, 1'b1);
    chk(safe_out, 2'b00);
    @(posedge clk);
    stim_r.mode_valid <= 1'b1;
    toggles(3, 1300, t);
    chk(t >= 2, 1'b1);
    @(posedge clk);
    stim_r.start_done <= 1'b1;
    step(4);
    toggles(3, 1300, t);
    chk({t[7:0], leds.power_led}, 9'h001);
  endtask
  // test pulses may be low at any sample, so outputs are judged as either one high
  task automatic t_run();
    @(posedge clk);
    stim_r.own_safety_ok <= 1'b1;
    step(4);
    chk({leds, safe_out.out_1 | safe_out.out_2}, 4'hf);
    @(posedge clk);
    and_cmd <= 1'b0;
    step(4);
    chk({leds, safe_out}, 5'h10);
    @(posedge clk);
    and_cmd <= 1'b1;
    or_cmd <= 1'b1;
    stim_r.own_safety_ok <= 1'b0;
    step(4);
    chk(leds, 3'h7);
    @(posedge clk);
    or_cmd <= 1'b0;
    step(4);
    chk({leds, safe_out}, 5'h10);
    @(posedge clk);
    stim_r.own_safety_ok <= 1'b1;
    step(4);
  endtask
  task automatic t_pulse();
    int len;
    wait_sig(1, 1'b0, 300);
    chk({leds, safe_out.out_2}, 4'hf);
    run_len(1, 1'b0, 40, len);
    chk(len, 20);
    @(posedge clk);
    stuck_2 <= 1'b1;
    wait_sig(0, 1'b1, 600);
    chk(safe_out, 2'b00);
    @(posedge clk);
    stuck_2 <= 1'b0;
    step(40);
    chk({leds.first_channel_led, leds.second_channel_led}, 2'b01);
  endtask
  task automatic t_restart();
    power_cycle(800);
    chk(fault_latched, 1'b1);
    power_cycle(2200);
    chk(fault_latched, 1'b0);
    wait_sig(1, 1'b1, 3000);
  endtask
  task automatic t_drop();
    power_cycle(36);
    chk(fault_latched, 1'b0);
    wait_sig(1, 1'b1, 3000);
    power_cycle(60);
    chk({fault_latched, safe_out}, 3'h4);
    t_restart();
  endtask
  task automatic t_alt();
    int same, t;
    @(posedge clk);
    stim_r.own_safety_ok <= 1'b0;
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      stim_r.feedback_open <= (k == 0);
      stim_r.one_channel_open <= (k == 1);
      step(4);
      same = 0;
      repeat (1100) begin
        same += (leds.first_channel_led === leds.second_channel_led);
        step(1);
      end
      toggles(2, 1100, t);
      chk({same[7:0], t >= 2}, 9'h001);
    end
    @(posedge clk);
    stim_r.one_channel_open <= 1'b0;
    step(4);
  endtask
  // code 1,0 on the first led: a one-flash digit, then zero as sixteen flashes
  task automatic t_code();
    int on, off, n;
    @(posedge clk);
    ext_code <= '{last: 2'h1, digit: 16'h0001};
    stim_r.ext_fault <= 1'b1;
    @(posedge clk);
    stim_r.ext_fault <= 1'b0;
    step(2);
    chk({fault_latched, safe_out}, 3'h4);
    for (int p = 0; p < 3; p++) begin
      flash(on, off);
      chk(on, D * SHORT_ON_MS);
      if (p < 2) chk(off, D * SHORT_OFF_MS);
    end
    chk(off >= D * PREFIX_PAUSE_MS && off <= D * (SHORT_OFF_MS + PREFIX_PAUSE_MS), 1'b1);
    for (int d = 0; d < 2; d++) begin
      n = 0;
      do begin
        flash(on, off);
        n++;
        chk(on, D * LONG_ON_MS);
      end while (off == D * LONG_OFF_MS && n < 20);
      chk(n, (d == 0) ? 1 : 16);
      chk(off >= D * DIGIT_PAUSE_MS && off <= D * (LONG_OFF_MS + DIGIT_PAUSE_MS), 1'b1);
    end
    flash(on, off);
    chk(on, D * SHORT_ON_MS);
  endtask

  // reset for 12 cycles, then the scenarios in turn
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    step(2);
    t_init();
    t_run();
    t_pulse();
    t_restart();
    t_drop();
    t_alt();
    t_code();
    test_done();
  end
endmodule

bind relay_status relay_status_sva #(.MS_DIV(MS_DIV)) u_sva (.clk(clk), .rst(rst), .status_in(status_in),
  .ext_code(ext_code), .leds(leds), .safe_out(safe_out), .fault_latched(fault_latched));
`default_nettype wire
